/* File: pkg/iwc_cfg.svh */
`ifndef IWC_CFG_SVH
`define IWC_CFG_SVH

// register byte offsets
`define IWC_OFF_RAW     8'h34
`define IWC_OFF_RXTHR   8'h38
`define IWC_OFF_TXTHR   8'h3C
`define IWC_OFF_CLRALL  8'h40
`define IWC_OFF_CLRUF   8'h44
`define IWC_OFF_IEN     8'h70
`define IWC_OFF_ICLR    8'h74
`define IWC_OFF_CFG     8'h78

// raw status bit positions
`define IWC_BIT_UF      0
`define IWC_BIT_RXFULL  2
`define IWC_BIT_TXEMPTY 4
`define IWC_BIT_RESTART 12
`define IWC_BIT_MHOLD   13

// config bit positions
`define IWC_CFG_RESTART 0
`define IWC_CFG_DYNTAR  1
`define IWC_CFG_EMPTYH  2

// widths, reset and compare values, htrans select bit
`define IWC_STAT_W      14
`define IWC_CFG_W       3
`define IWC_THR_RST     8'h00
`define IWC_LVL_ZERO    9'h000
`define IWC_WORD_ZERO   32'h0000_0000
`define IWC_HTRANS_NSQ  1

`endif

/* File: pkg/iwc_pkg.sv */
package iwc_pkg;

  // status coming from the bus protocol engine, same clock
  typedef struct packed {
    logic       rxUnderflowSet;
    logic       restartSeen;
    logic       slaveAddressed;
    logic       masterHolding;
    logic [8:0] rxLevel;
    logic [8:0] txLevel;
  } iwc_engine_t;

  // complete state of the block
  typedef struct packed {
    logic [7:0]  rxThr;
    logic [7:0]  txThr;
    logic [2:0]  cfg;
    logic [13:0] enable;
    logic        uf;
    logic        restart;
    logic        wrPend;
    logic [7:0]  wrAddr;
    logic [31:0] rdata;
    logic        clrAll;
  } iwc_state_t;

endpackage

/* File: src/iwc_irq_watermark.sv */
// Overview of operation
// R1: restart flag only when restart-detect option set
// R2: no restart flag before slave is addressed
// R3: bit 13 shows master holding on empty fifo
// R4: hold flag needs both dynamic and hold options
// R5: bit 2 set when rx level exceeds watermark
// R6: rx watermark writes clamp to fifo depth
// R7: rx watermark N means N+1 entries
// R8: bit 4 set when tx level below watermark
// R9: tx watermark writes clamp to fifo depth
// R10: tx watermark N means N entries
// R11: reading 0x40 clears all software flags, abort
// R12: combined clear leaves hardware level flags alone
// R13: reading 0x44 clears receive underflow bit 0
// R14: rx watermark resets to zero
// R15: watermark flags follow fifo level, no clear
`timescale 1ns/1ps
`include "iwc_cfg.svh"

module iwc_irq_watermark #(
  parameter int unsigned FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // protocol engine side
  input  wire iwc_pkg::iwc_engine_t engine,
  output logic                     clearAllPulse,
  output logic                     abortStatusClear,
  output logic                     rxFullFlag,
  output logic                     txEmptyFlag,
  // interrupt
  output logic                     irq
);

  // depth above 255 cannot be held in the 8-bit field
  localparam logic [8:0] DEPTH = 9'(FIFO_DEPTH);

  iwc_pkg::iwc_state_t s, n;

  logic                   accept;
  logic                   rdAcc;
  logic                   wrAcc;
  logic [7:0]             aOff;
  logic                   restartSet;
  logic                   mholdNow;
  logic [`IWC_STAT_W-1:0] rawStatus;
  logic [`IWC_STAT_W-1:0] swClear;
  logic                   clrAllHit;
  logic                   clrUfHit;
  logic [7:0]             wrByte;

  function automatic logic hit(input logic [7:0] off,
                               input logic [7:0] reg_off);
    hit = (off == reg_off);
  endfunction

  function automatic logic [7:0] clampThr(input logic [7:0] v);
    if ({1'b0, v} > DEPTH) begin
      clampThr = DEPTH[7:0];
    end else begin
      clampThr = v;
    end
  endfunction

  assign accept = hsel && hready && htrans[`IWC_HTRANS_NSQ];
  assign rdAcc  = accept && !hwrite;
  assign wrAcc  = accept && hwrite;
  assign aOff   = haddr[7:0];

  // single signals, so the past-value checks below can sample them
  assign clrAllHit = rdAcc && hit(aOff, `IWC_OFF_CLRALL);
  assign clrUfHit  = rdAcc && hit(aOff, `IWC_OFF_CLRUF);
  assign wrByte    = hwdata[7:0];

  // a restart ahead of the address field never counts
  assign restartSet = engine.restartSeen && engine.slaveAddressed //R2
                      && s.cfg[`IWC_CFG_RESTART]; //R1

  assign mholdNow = s.cfg[`IWC_CFG_DYNTAR] && s.cfg[`IWC_CFG_EMPTYH] //R4
                    && engine.masterHolding
                    && (engine.txLevel == `IWC_LVL_ZERO); //R3

  // level flags straight from the fifo fill, no sticky state
  assign rxFullFlag  = engine.rxLevel > {1'b0, s.rxThr}; //R5 R7 R15
  assign txEmptyFlag = engine.txLevel < {1'b0, s.txThr}; //R8 R10 R15

  always_comb begin
    rawStatus = '0;
    rawStatus[`IWC_BIT_UF]      = s.uf;
    rawStatus[`IWC_BIT_RXFULL]  = rxFullFlag;
    rawStatus[`IWC_BIT_TXEMPTY] = txEmptyFlag;
    rawStatus[`IWC_BIT_RESTART] = s.restart;
    rawStatus[`IWC_BIT_MHOLD]   = mholdNow;
  end

  function automatic logic [31:0] readReg(input logic [7:0] off,
                                          input iwc_pkg::iwc_state_t st);
    readReg = `IWC_WORD_ZERO;
    if (hit(off, `IWC_OFF_RAW)) begin
      readReg[`IWC_STAT_W-1:0] = rawStatus;
    end else if (hit(off, `IWC_OFF_RXTHR)) begin
      readReg[7:0] = st.rxThr;
    end else if (hit(off, `IWC_OFF_TXTHR)) begin
      readReg[7:0] = st.txThr;
    end else if (hit(off, `IWC_OFF_CLRALL)) begin
      readReg[0] = irq;
    end else if (hit(off, `IWC_OFF_CLRUF)) begin
      readReg[0] = st.uf;
    end else if (hit(off, `IWC_OFF_IEN)) begin
      readReg[`IWC_STAT_W-1:0] = st.enable;
    end else if (hit(off, `IWC_OFF_CFG)) begin
      readReg[`IWC_CFG_W-1:0] = st.cfg;
    end
  endfunction

  always_comb begin
    swClear = '0;
    n = s;
    n.clrAll = 1'b0;
    n.wrPend = wrAcc;
    if (wrAcc) begin
      n.wrAddr = aOff;
    end
    if (s.wrPend) begin
      if (hit(s.wrAddr, `IWC_OFF_RXTHR)) begin
        n.rxThr = clampThr(hwdata[7:0]); //R6
      end else if (hit(s.wrAddr, `IWC_OFF_TXTHR)) begin
        n.txThr = clampThr(hwdata[7:0]); //R9
      end else if (hit(s.wrAddr, `IWC_OFF_IEN)) begin
        n.enable = hwdata[`IWC_STAT_W-1:0];
      end else if (hit(s.wrAddr, `IWC_OFF_ICLR)) begin
        swClear = swClear | hwdata[`IWC_STAT_W-1:0];
      end else if (hit(s.wrAddr, `IWC_OFF_CFG)) begin
        n.cfg = hwdata[`IWC_CFG_W-1:0];
      end
    end
    if (rdAcc) begin
      // a read right behind a write must see the value just stored
      n.rdata = readReg(aOff, n);
      if (hit(aOff, `IWC_OFF_CLRALL)) begin
        // only sticky flags; level flags are left to hardware
        swClear[`IWC_BIT_UF]      = 1'b1; //R11 R12
        swClear[`IWC_BIT_RESTART] = 1'b1; //R11
        n.clrAll = 1'b1; //R11
      end else if (hit(aOff, `IWC_OFF_CLRUF)) begin
        swClear[`IWC_BIT_UF] = 1'b1; //R13
      end
    end
    // a new event in the clearing cycle survives the clear
    n.uf = engine.rxUnderflowSet
           || (s.uf && !swClear[`IWC_BIT_UF]); //R13
    n.restart = restartSet
                || (s.restart && !swClear[`IWC_BIT_RESTART]); //R1
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.rxThr  <= `IWC_THR_RST; //R14
      s.txThr  <= `IWC_THR_RST;
      s.cfg    <= '0;
      s.enable <= '0;
      s.uf     <= 1'b0;
      s.restart <= 1'b0;
      s.wrPend <= 1'b0;
      s.wrAddr <= '0;
      s.rdata  <= `IWC_WORD_ZERO;
      s.clrAll <= 1'b0;
    end else begin
      s <= n;
    end
  end

  // zero wait states; bus never stalls or errors
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = s.rdata;
  assign clearAllPulse    = s.clrAll;
  assign abortStatusClear = s.clrAll; //R11
  assign irq              = |(rawStatus & s.enable);

  // rule checks, all on core_clk and off during reset
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence clrAllRead;
    rdAcc && hit(aOff, `IWC_OFF_CLRALL) && !engine.rxUnderflowSet
      && !restartSet;
  endsequence

  sequence clrUfRead;
    rdAcc && hit(aOff, `IWC_OFF_CLRUF) && !engine.rxUnderflowSet
      && !restartSet && !s.wrPend;
  endsequence

  sequence rxThrWrite;
    wrAcc && hit(aOff, `IWC_OFF_RXTHR) ##1 ({1'b0, hwdata[7:0]} > DEPTH);
  endsequence

  sequence txThrWrite;
    wrAcc && hit(aOff, `IWC_OFF_TXTHR) ##1 ({1'b0, hwdata[7:0]} > DEPTH);
  endsequence

  sequence rxThrStore;
    wrAcc && hit(aOff, `IWC_OFF_RXTHR) ##1 ({1'b0, wrByte} <= DEPTH);
  endsequence

  sequence txThrStore;
    wrAcc && hit(aOff, `IWC_OFF_TXTHR) ##1 ({1'b0, wrByte} <= DEPTH);
  endsequence

  restart_opt_a: assert property ( //R1
    !s.restart && !s.cfg[`IWC_CFG_RESTART] |=> !s.restart)
    else $error("restart flag set with detect option off");

  restart_addr_a: assert property ( //R2
    !s.restart && !engine.slaveAddressed |=> !s.restart)
    else $error("restart flag set while slave not addressed");

  hold_flag_a: assert property ( //R3
    s.cfg[`IWC_CFG_DYNTAR] && s.cfg[`IWC_CFG_EMPTYH]
      && engine.masterHolding && engine.txLevel == `IWC_LVL_ZERO
      |-> rawStatus[`IWC_BIT_MHOLD])
    else $error("hold flag missing on empty fifo hold");

  hold_opt_a: assert property ( //R4
    !(s.cfg[`IWC_CFG_DYNTAR] && s.cfg[`IWC_CFG_EMPTYH])
      |-> !rawStatus[`IWC_BIT_MHOLD])
    else $error("hold flag set without both options");

  rx_full_a: assert property ( //R5
    engine.rxLevel == {1'b0, s.rxThr} + 9'h001 |-> rxFullFlag)
    else $error("rx full flag missing at threshold plus one");

  rx_offset_a: assert property ( //R7
    engine.rxLevel == {1'b0, s.rxThr} |-> !rxFullFlag)
    else $error("rx full flag set at programmed value");

  rx_clamp_a: assert property ( //R6
    rxThrWrite |=> s.rxThr == DEPTH[7:0])
    else $error("rx watermark not clamped to depth");

  tx_clamp_a: assert property ( //R9
    txThrWrite |=> s.txThr == DEPTH[7:0])
    else $error("tx watermark not clamped to depth");

  tx_empty_a: assert property ( //R8
    engine.txLevel + 9'h001 == {1'b0, s.txThr} |-> txEmptyFlag)
    else $error("tx empty flag missing below watermark");

  tx_direct_a: assert property ( //R10
    engine.txLevel == {1'b0, s.txThr} |-> !txEmptyFlag)
    else $error("tx empty flag set at programmed value");

  clear_all_a: assert property ( //R11
    clrAllRead |=> !s.uf && !s.restart && clearAllPulse
      && abortStatusClear)
    else $error("combined clear read left a flag set");

  level_keep_a: assert property ( //R12
    (clrAllRead and (rxFullFlag && $stable(engine.rxLevel)))
      ##1 ($stable(engine.rxLevel) && $stable(s.rxThr)) |-> rxFullFlag)
    else $error("combined clear disturbed a level flag");

  uf_clear_a: assert property ( //R13
    clrUfRead |=> !s.uf ##0 $stable(s.restart))
    else $error("underflow read did not clear bit 0");

  level_follow_a: assert property ( //R15
    rxFullFlag && engine.rxLevel <= {1'b0, s.rxThr} |-> 1'b0)
    else $error("rx full flag held after level dropped");

  uf_set_a: assert property ( //R13
    engine.rxUnderflowSet |=> s.uf)
    else $error("underflow event lost to a clear");

  restart_set_a: assert property ( //R1
    restartSet |=> s.restart)
    else $error("addressed restart not flagged");

  clr_pulse_a: assert property ( //R11
    clearAllPulse |-> $past(clrAllHit))
    else $error("clear strobe without a combined clear read");

  clr_read_a: assert property ( //R11
    clrAllHit |=> hrdata[0] == $past(irq))
    else $error("combined clear read lost the interrupt state");

  uf_read_a: assert property ( //R13
    clrUfHit |=> hrdata[0] == $past(s.uf))
    else $error("underflow clear read lost the flag state");

  // legal values are stored as written, no offset applied
  rx_store_a: assert property ( //R6
    rxThrStore |=> s.rxThr == $past(wrByte))
    else $error("rx watermark not stored as written");

  tx_store_a: assert property ( //R9
    txThrStore |=> s.txThr == $past(wrByte))
    else $error("tx watermark not stored as written");

  thr_range_a: assert property ( //R6
    ({1'b0, s.rxThr} <= DEPTH) && ({1'b0, s.txThr} <= DEPTH))
    else $error("watermark above fifo depth");

  thr_hold_a: assert property ( //R9
    !s.wrPend |=> $stable(s.rxThr) && $stable(s.txThr))
    else $error("watermark changed without a write");

  rx_zero_a: assert property ( //R7
    s.rxThr == `IWC_THR_RST && engine.rxLevel != `IWC_LVL_ZERO
      |-> rxFullFlag)
    else $error("rx watermark zero did not mean one entry");

  tx_zero_a: assert property ( //R10
    s.txThr == `IWC_THR_RST |-> !txEmptyFlag)
    else $error("tx empty flag set with watermark zero");

  tx_low_a: assert property ( //R8
    engine.txLevel == `IWC_LVL_ZERO && s.txThr != `IWC_THR_RST
      |-> txEmptyFlag)
    else $error("tx empty flag missing with fifo empty");

  hold_follow_a: assert property ( //R3
    rawStatus[`IWC_BIT_MHOLD]
      |-> engine.masterHolding && engine.txLevel == `IWC_LVL_ZERO)
    else $error("hold flag set while fifo not empty");

  irq_uf_a: assert property ( //R11
    s.uf && s.enable[`IWC_BIT_UF] |-> irq)
    else $error("enabled underflow flag not on the interrupt");

endmodule

/* File: verif/iwc_engine_model.sv */
`timescale 1ns/1ps
module iwc_engine_model (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // bench request and engine view
  input  wire iwc_pkg::iwc_engine_t  cmd,
  output iwc_pkg::iwc_engine_t       engineQ
);
  // registered: a request reaches the block one edge later, as from a core
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      engineQ <= '0;
    else
      engineQ <= cmd;
  end
endmodule

/* File: verif/iwc_irq_watermark_tb.sv */
`timescale 1ns/1ps
module iwc_irq_watermark_tb;
  typedef struct packed {
    logic [7:0]  off;
    logic [31:0] wv;
    logic [7:0]  ex;
    logic [8:0]  rxl;
    logic [8:0]  txl;
    logic        erx;
    logic        etx;
  } iwc_row_t;
  logic                 core_clk, rst_n, hwrite, hreadyout, hresp, irq;
  logic                 clearAllPulse, abortStatusClear, rxFullFlag;
  logic                 txEmptyFlag;
  logic [1:0]           htrans;
  logic [31:0]          haddr, hwdata, hrdata, rd;
  iwc_pkg::iwc_engine_t cmd, engineQ;
  int                   errCount, numChecks, pulseCnt, n0;
  // depth 16: writes above it read back 0x10
  iwc_row_t rows [9] = '{
    '{8'h38, 32'h0000_0005, 8'h05, 9'h005, 9'h000, 1'b0, 1'b0},
    '{8'h38, 32'h0000_0005, 8'h05, 9'h006, 9'h000, 1'b1, 1'b0},
    '{8'h3C, 32'h0000_0009, 8'h09, 9'h006, 9'h008, 1'b1, 1'b1},
    '{8'h3C, 32'h0000_0009, 8'h09, 9'h000, 9'h009, 1'b0, 1'b0},
    '{8'h38, 32'h0000_0011, 8'h10, 9'h010, 9'h009, 1'b0, 1'b0},
    '{8'h38, 32'h0000_00FF, 8'h10, 9'h011, 9'h000, 1'b1, 1'b1},
    '{8'h3C, 32'h0000_0011, 8'h10, 9'h000, 9'h00F, 1'b0, 1'b1},
    '{8'h3C, 32'h0000_0000, 8'h00, 9'h000, 9'h000, 1'b0, 1'b0},
    '{8'h38, 32'hFFFF_FF00, 8'h00, 9'h001, 9'h000, 1'b1, 1'b0}};

  iwc_engine_model em (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd),
    .engineQ(engineQ));
  iwc_irq_watermark uut (.core_clk(core_clk), .rst_n(rst_n), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .engine(engineQ),
    .clearAllPulse(clearAllPulse), .abortStatusClear(abortStatusClear),
    .rxFullFlag(rxFullFlag), .txEmptyFlag(txEmptyFlag), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // both clear strobes come from one flop, so count them together
  always @(posedge core_clk)
    if (clearAllPulse === 1'b1 && abortStatusClear === 1'b1) pulseCnt++;

  task automatic finishTest();
    if (errCount == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      errCount++;
      finishTest();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic pulse(input logic uf, input logic rs);
    cmd.rxUnderflowSet <= uf;
    cmd.restartSeen <= rs;
    @(posedge core_clk);
    cmd.rxUnderflowSet <= 1'b0;
    cmd.restartSeen <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  initial begin
    rst_n = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    cmd = '0;
    errCount = 0;
    numChecks = 0;
    pulseCnt = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk(8'h38, 32'h0000_0000);
    rdchk(8'h3C, 32'h0000_0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].off, rows[i].wv);
      cmd.rxLevel <= rows[i].rxl;
      cmd.txLevel <= rows[i].txl;
      rdchk(rows[i].off, {24'h00_0000, rows[i].ex});
      chk({31'h0000_0000, rxFullFlag}, {31'h0000_0000, rows[i].erx});
      chk({31'h0000_0000, txEmptyFlag}, {31'h0000_0000, rows[i].etx});
      rdchk(8'h34, {27'h000_0000, rows[i].etx, 1'b0, rows[i].erx, 2'h0});
    end
    // rx level 1 over threshold 0 keeps raw bit 2 up until the rx watermark is rewritten to 3
    cmd.slaveAddressed <= 1'b1;
    pulse(1'b0, 1'b1);
    rdchk(8'h34, 32'h0000_0004);
    bus(1'b1, 8'h78, 32'h0000_0001);
    cmd.slaveAddressed <= 1'b0;
    pulse(1'b0, 1'b1);
    rdchk(8'h34, 32'h0000_0004);
    cmd.slaveAddressed <= 1'b1;
    pulse(1'b0, 1'b1);
    rdchk(8'h34, 32'h0000_1004);
    cmd.masterHolding <= 1'b1;
    rdchk(8'h34, 32'h0000_1004);
    bus(1'b1, 8'h78, 32'h0000_0003);
    rdchk(8'h34, 32'h0000_1004);
    bus(1'b1, 8'h78, 32'h0000_0005);
    rdchk(8'h34, 32'h0000_1004);
    bus(1'b1, 8'h78, 32'h0000_0007);
    rdchk(8'h34, 32'h0000_3004);
    pulse(1'b1, 1'b0);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rdchk(8'h44, 32'h0000_0001);
    rdchk(8'h34, 32'h0000_3004);
    pulse(1'b1, 1'b0);
    bus(1'b1, 8'h70, 32'h0000_0001);
    @(posedge core_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    bus(1'b1, 8'h74, 32'h0000_0001);
    @(posedge core_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rdchk(8'h34, 32'h0000_3004);
    pulse(1'b1, 1'b0);
    bus(1'b1, 8'h70, 32'h0000_1001);
    n0 = pulseCnt;
    rdchk(8'h40, 32'h0000_0001);
    rdchk(8'h34, 32'h0000_2004);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    chk(32'(pulseCnt - n0), 32'h0000_0001);
    rdchk(8'h80, 32'h0000_0000);
    rdchk(8'h78, 32'h0000_0007);
    bus(1'b1, 8'h38, 32'h0000_0003);
    rdchk(8'h38, 32'h0000_0003);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk(8'h78, 32'h0000_0000);
    rdchk(8'h70, 32'h0000_0000);
    rdchk(8'h38, 32'h0000_0000);
    finishTest();
  end
endmodule
